/* File: floppy_result_status_regs.sv */
`timescale 1ns/1ps
// How it works
// - FIFO data port at offset 5 shows one of four result bytes per read in the result phase, else the transfer byte.
// - FIFO is disabled after reset; only the configure command enables it.
// - Result status 0 bits 7-6 hold the command termination code.
// - Result status 0 bit 5 is 1 on seek end, 0 on seek failure.
// - Result status 0 bit 4 set on drive fault or 77 steps without signal.
// - Result status 0 bit 3 is 1 when the drive is ready.
// - Result status 0 bit 2 head, bits 1-0 selected drive.
// - Result status 1 bit 7 set on access beyond last sector.
// - Reserved result bits 1.6, 1.3 and 2.7 always read zero.
// - Result status 1 bit 5 set on ID or data field CRC failure.
// - Result status 1 bit 4 set when host misses a transfer byte.
// - Result status 1 bit 2 set when the sector cannot be found.
// - Result status 1 bit 1 set on write protect during write data.
// - Result status 1 bit 0 set on missing or deleted address mark.
// - Result status 2 bit 6 set on control mark in read or scan.
// - Result status 2 bit 5 set only for data field CRC failure.
// - Result status 2 bit 4 wrong cylinder, bit 1 bad cylinder.
// - Scan sets result status 2 bit 3 on equal, bit 2 on unmet.
// - Result status 2 bit 0 set on missing or deleted data mark.
// - Result status 3 reports the drive lines in fixed bit order.
// - Offset 7 is read-only; bit 7 is the inverse of media_changed_n.
// - Bits 6-0 of offset 7 are left undriven on a read.
module floppy_result_status_regs
  import floppy_status_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int RESULT_BYTES = RESULT_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave, word addressed
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Lane enables of the shared data bus, low while a lane is driven
  output logic [6:0] dataLaneOe_n,
  // Controller core side
  input wire logic cmdStart,
  input wire logic cmdDone,
  input wire floppy_status_pkg::termination_kind_t termKind,
  input wire logic configStrobe,
  input wire logic configFifoEnable,
  input wire logic writeCmdActive,
  input wire logic readOrScanActive,
  input wire logic scanActive,
  input wire logic seekEnd,
  input wire logic seekFail,
  input wire logic recalStep,
  input wire logic trackZeroSeen,
  input wire logic endOfTrack,
  input wire logic idCrcFault,
  input wire logic dataFieldCrcFault,
  input wire logic sectorAbsent,
  input wire logic addrMarkMissing,
  input wire logic deletedMarkSeen,
  input wire logic wrongTrack,
  input wire logic badTrack,
  input wire logic scanEqualHit,
  input wire logic scanUnmet,
  input wire logic xferByteValid,
  input wire logic [7:0] xferByte,
  input wire logic [1:0] unitSel,
  input wire logic headNumber,
  // Drive lines
  input wire logic driveFaultLine,
  input wire logic writeProtectLine,
  input wire logic driveReadyLine,
  input wire logic trackZeroLine,
  input wire logic twoSidedLine,
  input wire logic media_changed_n,
  // Toward the core
  output logic fifoEnabled,
  output logic cmdByteValid,
  output logic [7:0] cmdByte,
  output logic resultPending
);

  initial begin
    if (ADDR_W < 3) begin
      $error("ADDR_W must reach offset 7");
    end
    if (RESULT_BYTES != RESULT_DEPTH) begin
      $error("result stack holds exactly four bytes");
    end
  end

  logic ack_r;
  logic [31:0] readdata_r;
  logic [6:0] laneOe_n_r;
  logic fifoEn_r;
  logic [7:0] cmdByte_r;
  logic cmdByteValid_r;
  logic [7:0] rs0_r;
  logic [7:0] rs1_r;
  logic [7:0] rs2_r;
  logic [7:0] rs3_r;
  logic [1:0] rdSlot_r;
  logic resultPending_r;
  logic [7:0] xferData_r;
  logic xferPending_r;
  logic [6:0] recalCount_r;
  logic mediaSense_r;
  logic [7:0] rs1_nxt;
  logic [7:0] rs2_nxt;
  logic [7:0] fifoReadByte;
  logic accept;
  logic hitFifo;
  logic hitMedia;
  logic popResult;
  logic overrunEvt;
  logic recalGiveUp;

  // One wait state: the request is answered on the second cycle
  assign waitrequest = (read | write) & ~ack_r;
  assign accept = (read | write) & ack_r;
  assign hitFifo = address == ADDR_W'(FIFO_DATA_PORT_IDX);
  assign hitMedia = address == ADDR_W'(MEDIA_SENSE_IDX);
  assign popResult = accept & read & hitFifo & resultPending_r;
  assign readdata = readdata_r;
  assign dataLaneOe_n = laneOe_n_r;
  assign fifoEnabled = fifoEn_r;
  assign cmdByte = cmdByte_r;
  assign cmdByteValid = cmdByteValid_r;
  assign resultPending = resultPending_r;

  // A new transfer byte while the last is unread is an overrun
  assign overrunEvt = xferByteValid & xferPending_r &
                      ~(accept & read & hitFifo);
  assign recalGiveUp = recalStep & ~trackZeroSeen &
                       (recalCount_r == RECAL_STEP_LIMIT_V - 7'h01);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // Only one result byte is visible per read slot
  always_comb begin
    unique case (rdSlot_r)
      2'h0: fifoReadByte = rs0_r;
      2'h1: fifoReadByte = rs1_r;
      2'h2: fifoReadByte = rs2_r;
      2'h3: fifoReadByte = rs3_r;
    endcase
    if (!resultPending_r) begin
      fifoReadByte = xferData_r;
    end
  end

  // Read data is loaded in the waiting cycle so it stands at the accept edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_r <= 32'h0000_0000;
      laneOe_n_r <= 7'h00;
    end else if (read & ~ack_r) begin
      laneOe_n_r <= 7'h00;
      if (hitFifo) begin
        readdata_r <= {24'h00_0000, fifoReadByte};
      end else if (hitMedia) begin
        readdata_r <= {24'h00_0000, mediaSense_r, 7'h00};
        laneOe_n_r <= MEDIA_UNDRIVEN_MASK;
      end else begin
        readdata_r <= 32'h0000_0000;
      end
    end else if (!read) begin
      laneOe_n_r <= 7'h00;
    end
  end

  // Inverse of the change line; the reset value makes bit 7 read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mediaSense_r <= 1'b0;
    end else begin
      mediaSense_r <= ~media_changed_n;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifoEn_r <= FIFO_EN_RESET;
    end else if (configStrobe) begin
      fifoEn_r <= configFifoEnable;
    end
  end

  // Host writes to the port go to the command decoder as bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmdByte_r <= 8'h00;
      cmdByteValid_r <= 1'b0;
    end else begin
      cmdByteValid_r <= accept & write & hitFifo & byteenable[0];
      if (accept & write & hitFifo & byteenable[0]) begin
        cmdByte_r <= writedata[7:0];
      end
    end
  end

  // Execution-phase byte holding register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xferData_r <= 8'h00;
      xferPending_r <= 1'b0;
    end else begin
      if (xferByteValid) begin
        xferData_r <= xferByte;
      end
      if (xferByteValid) begin
        xferPending_r <= 1'b1;
      end else if (accept & read & hitFifo & ~resultPending_r) begin
        xferPending_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | cmdStart) begin
      recalCount_r <= 7'h00;
    end else if (recalStep) begin
      recalCount_r <= recalCount_r + 7'h01;
    end
  end

  // Error flags gather during a command; a set beats the clear at start
  always_comb begin
    rs1_nxt = cmdStart ? RESULT_RESET : rs1_r;
    rs2_nxt = cmdStart ? RESULT_RESET : rs2_r;
    if (endOfTrack) begin
      rs1_nxt[RS1_END_OF_TRACK] = 1'b1;
    end
    if (idCrcFault | dataFieldCrcFault) begin
      rs1_nxt[RS1_ID_CRC_FAULT] = 1'b1;
    end
    if (overrunEvt) begin
      rs1_nxt[RS1_OVERRUN] = 1'b1;
    end
    if (sectorAbsent) begin
      rs1_nxt[RS1_SECTOR_ABSENT] = 1'b1;
    end
    if (writeProtectLine & writeCmdActive) begin
      rs1_nxt[RS1_WRITE_BLOCKED] = 1'b1;
    end
    if (addrMarkMissing | deletedMarkSeen) begin
      rs1_nxt[RS1_ADDR_MARK_MISSING] = 1'b1;
    end
    if (deletedMarkSeen & readOrScanActive) begin
      rs2_nxt[RS2_CONTROL_MARK_HIT] = 1'b1;
    end
    if (dataFieldCrcFault) begin
      rs2_nxt[RS2_DATA_FIELD_CRC_FAULT] = 1'b1;
    end
    if (wrongTrack) begin
      rs2_nxt[RS2_WRONG_TRACK] = 1'b1;
    end
    if (badTrack) begin
      rs2_nxt[RS2_BAD_TRACK] = 1'b1;
    end
    if (scanActive & scanEqualHit) begin
      rs2_nxt[RS2_SCAN_EQUAL_HIT] = 1'b1;
    end
    if (scanActive & scanUnmet) begin
      rs2_nxt[RS2_SCAN_UNMET] = 1'b1;
    end
    if (readOrScanActive & (addrMarkMissing | deletedMarkSeen)) begin
      rs2_nxt[RS2_DATA_MARK_MISSING] = 1'b1;
    end
    rs1_nxt[6] = 1'b0;
    rs1_nxt[3] = 1'b0;
    rs2_nxt[7] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs1_r <= RESULT_RESET;
      rs2_r <= RESULT_RESET;
    end else begin
      rs1_r <= rs1_nxt;
      rs2_r <= rs2_nxt;
    end
  end

  // Result status 0: fault and seek bits gather, the rest load at the end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs0_r <= RESULT_RESET;
    end else begin
      if (cmdStart) begin
        rs0_r[RS0_EQUIPMENT_FAULT] <= 1'b0;
        rs0_r[RS0_POSITIONING_DONE] <= 1'b0;
      end
      if (seekEnd) begin
        rs0_r[RS0_POSITIONING_DONE] <= 1'b1;
      end else if (seekFail) begin
        rs0_r[RS0_POSITIONING_DONE] <= 1'b0;
      end
      if (driveFaultLine | recalGiveUp) begin
        rs0_r[RS0_EQUIPMENT_FAULT] <= 1'b1;
      end
      if (cmdDone) begin
        rs0_r[RS0_TERM_HI:RS0_TERM_LO] <= termKind;
        rs0_r[RS0_DRIVE_READY] <= driveReadyLine;
        rs0_r[RS0_HEAD] <= headNumber;
        rs0_r[1:0] <= unitSel;
      end
    end
  end

  // Drive line snapshot taken when the result phase opens
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs3_r <= RESULT_RESET;
    end else if (cmdDone) begin
      rs3_r <= {driveFaultLine, writeProtectLine, driveReadyLine,
                trackZeroLine, twoSidedLine, headNumber,
                unitSel};
    end
  end

  // Result phase: four reads walk the stack, then the port returns to data
  always_ff @(posedge clk) begin
    if (sys_rst | cmdStart) begin
      rdSlot_r <= RS0_SLOT;
      resultPending_r <= 1'b0;
    end else if (cmdDone) begin
      rdSlot_r <= RS0_SLOT;
      resultPending_r <= 1'b1;
    end else if (popResult) begin
      rdSlot_r <= rdSlot_r + 2'h1;
      if (rdSlot_r == RS3_SLOT) begin
        resultPending_r <= 1'b0;
      end
    end
  end

endmodule

/* File: floppy_status_pkg.sv */
package floppy_status_pkg;

  // Register word indices; the Avalon address is a word address
  localparam logic [2:0] FIFO_DATA_PORT_IDX = 3'h5;
  localparam logic [2:0] MEDIA_SENSE_IDX = 3'h7;

  // Result stack depth and read order
  localparam int RESULT_DEPTH = 4;
  localparam logic [1:0] RS0_SLOT = 2'h0;
  localparam logic [1:0] RS3_SLOT = 2'h3;

  // Termination kinds in result status 0 bits 7-6
  typedef enum logic [1:0] {
    TERM_NORMAL = 2'b00,
    TERM_ABNORMAL = 2'b01,
    TERM_INVALID = 2'b10,
    TERM_EXEC_ABORT = 2'b11
  } termination_kind_t;

  // Result status 0 fields
  localparam int RS0_TERM_HI = 7;
  localparam int RS0_TERM_LO = 6;
  localparam int RS0_POSITIONING_DONE = 5;
  localparam int RS0_EQUIPMENT_FAULT = 4;
  localparam int RS0_DRIVE_READY = 3;
  localparam int RS0_HEAD = 2;

  // Result status 1 fields
  localparam int RS1_END_OF_TRACK = 7;
  localparam int RS1_ID_CRC_FAULT = 5;
  localparam int RS1_OVERRUN = 4;
  localparam int RS1_SECTOR_ABSENT = 2;
  localparam int RS1_WRITE_BLOCKED = 1;
  localparam int RS1_ADDR_MARK_MISSING = 0;

  // Result status 2 fields
  localparam int RS2_CONTROL_MARK_HIT = 6;
  localparam int RS2_DATA_FIELD_CRC_FAULT = 5;
  localparam int RS2_WRONG_TRACK = 4;
  localparam int RS2_SCAN_EQUAL_HIT = 3;
  localparam int RS2_SCAN_UNMET = 2;
  localparam int RS2_BAD_TRACK = 1;
  localparam int RS2_DATA_MARK_MISSING = 0;

  // Result status 3 fields
  localparam int RS3_FAULT = 7;
  localparam int RS3_WRITE_PROTECT = 6;
  localparam int RS3_READY = 5;
  localparam int RS3_TRACK_ZERO = 4;
  localparam int RS3_TWO_SIDED = 3;
  localparam int RS3_HEAD = 2;

  // Media sense register
  localparam int MEDIA_CHANGED_BIT = 7;
  localparam logic [6:0] MEDIA_UNDRIVEN_MASK = 7'h7F;

  // Equipment check gives up after this many recalibrate steps
  localparam int RECAL_STEP_LIMIT = 77;
  localparam logic [6:0] RECAL_STEP_LIMIT_V = 7'(RECAL_STEP_LIMIT);

  // Reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic FIFO_EN_RESET = 1'b0;

endpackage

/* File: floppy_status_properties.sv */
`timescale 1ns/1ps
module floppy_status_properties #(
  parameter int ADDR_W = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [6:0] dataLaneOe_n,
  input wire logic cmdStart,
  input wire logic cmdDone,
  input wire logic configStrobe,
  input wire logic configFifoEnable,
  input wire logic media_changed_n,
  input wire logic fifoEnabled,
  input wire logic cmdByteValid,
  input wire logic [7:0] cmdByte,
  input wire logic resultPending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic takeRd = read && !waitrequest;
  wire logic at5 = address == ADDR_W'(3'h5);
  wire logic at7 = address == ADDR_W'(3'h7);

  wait_state_a: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("request still waiting after one wait state");
  upper_zero_a: assert property (
    takeRd |-> readdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  unmapped_zero_a: assert property (
    takeRd && !at5 && !at7 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // Media line must be steady long enough to pass its sync stage
  media_bit_a: assert property (
    takeRd && at7 && $stable(media_changed_n) &&
    $past(media_changed_n) == $past(media_changed_n, 2) |->
    readdata[7:0] == {!media_changed_n, 7'h00})
    else $error("media bit does not follow input");
  lanes_off_a: assert property (
    takeRd && at7 |-> dataLaneOe_n == 7'h7F)
    else $error("lower lanes driven on media read");
  lanes_idle_a: assert property (
    !read && !$past(read) |-> dataLaneOe_n == 7'h00)
    else $error("lanes released while idle");
  fifo_hold_a: assert property (
    !configStrobe |=> $stable(fifoEnabled))
    else $error("fifo enable changed without configure");
  fifo_cfg_a: assert property (
    configStrobe |=> fifoEnabled == $past(configFifoEnable))
    else $error("configure did not set fifo enable");
  result_open_a: assert property (
    cmdDone && !cmdStart |=> resultPending)
    else $error("result phase not opened");
  cmd_byte_a: assert property (
    write && !waitrequest && at5 && byteenable[0] |=>
    cmdByteValid && cmdByte == $past(writedata[7:0]))
    else $error("command byte not passed on");
endmodule

/* File: host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model #(
  parameter int ADDR_W = 3
) (
  input wire logic clk,
  input wire logic waitrequest,
  output logic [ADDR_W-1:0] address = '0,
  output logic read = 1'b0,
  output logic write = 1'b0,
  output logic [31:0] writedata = 32'h0,
  output logic [3:0] byteenable = 4'hF
);
  // One access; an edge passes first so strobes never toggle twice at once
  task automatic access(input logic [ADDR_W-1:0] a, input logic wrEn,
                        input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    read <= !wrEn;
    write <= wrEn;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import floppy_status_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] address;
  logic read, write, waitrequest;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic fifoEnabled;
  logic cmdStart = 1'b0, cmdDone = 1'b0, configStrobe = 1'b0;
  logic configFifoEnable = 1'b0, recalStep = 1'b0, xv = 1'b0;
  logic mcn = 1'b1;
  logic [1:0] tk = 2'h0;
  logic [31:0] sig = 32'h0, r, seed = 32'hF8FA;
  logic [7:0] ex[4];
  logic [7:0] lastB = 8'h00;
  logic [15:0] e;
  logic [15:0] expQ[$];
  int failures = 0;
  int n_tests = 0;

  always #12.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Mask keeps only the lanes the host may trust
  task automatic rd(input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] x);
    expQ.push_back({m, x});
    host.access(a, 1'b0, 8'h00);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      e = expQ.pop_front();
      cmp(readdata[7:0] & e[15:8], e[7:0]);
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    cmp({7'h00, fifoEnabled}, 8'h00);
    rd(3'h7, 8'h80, 8'h00);
    mcn <= 1'b0;
    repeat (3) @(posedge clk);
    rd(3'h7, 8'h80, 8'h80);
    host.access(3'h7, 1'b1, 8'h00);
    rd(3'h7, 8'h80, 8'h80);
    rd(3'h2, 8'hFF, 8'h00);
    configStrobe <= 1'b1;
    configFifoEnable <= 1'b1;
    @(posedge clk);
    configStrobe <= 1'b0;
    @(posedge clk);
    cmp({7'h00, fifoEnabled}, 8'h01);
    host.access(3'h5, 1'b1, seed[15:8]);
    for (int k = 0; k < 4; k++) begin
      rd(3'h5, 8'hFF, lastB);
      seed = xs(seed);
      r = seed;
      @(posedge clk);
      cmdStart <= 1'b1;
      sig <= 32'h0;
      @(posedge clk);
      cmdStart <= 1'b0;
      sig <= r;
      xv <= r[24];
      repeat (2) @(posedge clk);
      xv <= 1'b0;
      // Only the last round reaches the step limit
      repeat (k == 3 ? 77 : 76) begin
        recalStep <= 1'b1;
        @(posedge clk);
        recalStep <= 1'b0;
        @(posedge clk);
      end
      sig <= r & 32'hFFE7FC00;
      cmdDone <= 1'b1;
      tk <= k[1:0];
      @(posedge clk);
      cmdDone <= 1'b0;
      ex[0] = {k[1:0], r[19], r[14] | (k == 3 && !r[23]), r[15], r[18],
               r[22:21]};
      ex[1] = {r[0], 1'b0, r[1] | r[2], r[24], 1'b0, r[3], r[13] & r[10],
               r[4] | r[5]};
      ex[2] = {1'b0, r[5] & r[11], r[2], r[6], r[12] & r[8], r[12] & r[9],
               r[7], r[11] & (r[4] | r[5])};
      ex[3] = {r[14], r[13], r[15], r[16], r[17], r[18], r[22:21]};
      rd(3'h5, 8'hFF, ex[0]);
      rd(3'h5, 8'hFF, ex[1]);
      rd(3'h5, 8'hFF, ex[2]);
      rd(3'h5, 8'hFF, ex[3]);
      if (r[24]) lastB = r[31:24];
    end
    @(posedge clk);
    give_verdict();
  end

  host_bus_model host (.clk(clk), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));

  floppy_result_status_regs DUT (.clk(clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .dataLaneOe_n(), .cmdStart(cmdStart),
    .cmdDone(cmdDone), .termKind(termination_kind_t'(tk)),
    .configStrobe(configStrobe), .configFifoEnable(configFifoEnable),
    .writeCmdActive(sig[10]), .readOrScanActive(sig[11]),
    .scanActive(sig[12]), .seekEnd(sig[19]), .seekFail(sig[20]),
    .recalStep(recalStep), .trackZeroSeen(sig[23]),
    .endOfTrack(sig[0]), .idCrcFault(sig[1]), .dataFieldCrcFault(sig[2]),
    .sectorAbsent(sig[3]), .addrMarkMissing(sig[4]),
    .deletedMarkSeen(sig[5]), .wrongTrack(sig[6]), .badTrack(sig[7]),
    .scanEqualHit(sig[8]), .scanUnmet(sig[9]), .xferByteValid(xv),
    .xferByte(sig[31:24]), .unitSel(sig[22:21]), .headNumber(sig[18]),
    .driveFaultLine(sig[14]), .writeProtectLine(sig[13]),
    .driveReadyLine(sig[15]), .trackZeroLine(sig[16]),
    .twoSidedLine(sig[17]), .media_changed_n(mcn),
    .fifoEnabled(fifoEnabled), .cmdByteValid(), .cmdByte(),
    .resultPending());
endmodule

bind floppy_result_status_regs floppy_status_properties #(.ADDR_W(ADDR_W))
  chk (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .dataLaneOe_n(dataLaneOe_n), .cmdStart(cmdStart), .cmdDone(cmdDone),
  .configStrobe(configStrobe), .configFifoEnable(configFifoEnable),
  .media_changed_n(media_changed_n), .fifoEnabled(fifoEnabled),
  .cmdByteValid(cmdByteValid), .cmdByte(cmdByte),
  .resultPending(resultPending));
